//--- core/msc_consts.svh
/*
 * Offsets, field positions, reset values and widths of the second-stream
 * transfer-unit configuration bank.
 * Assumes byte addresses on a 12-bit register port, one word per register.
 */
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MSC_OFF_TU_SIZE        12'h530
`define MSC_OFF_WORD_COUNT     12'h53c
`define MSC_OFF_INTERLACE      12'h540
`define MSC_OFF_MIN_BYTES      12'h544
`define MSC_OFF_FRAC_BYTES     12'h548
`define MSC_OFF_LINE_WAIT      12'h54c

// ----------------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------------
`define MSC_ADDR_W             12
`define MSC_DATA_W             32
`define MSC_WORD_COUNT_W       16
`define MSC_MIN_BYTES_W        8
`define MSC_FRAC_BYTES_W       10
`define MSC_LINE_WAIT_W        8
`define MSC_TU_SIZE_W          7
`define MSC_INTERLACE_BIT      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MSC_RST_TU_SIZE        7'h40
`define MSC_RST_WORD_COUNT     16'h0000
`define MSC_RST_MIN_BYTES      8'h00
`define MSC_RST_FRAC_BYTES     10'h000
`define MSC_RST_LINE_WAIT      8'h00

`endif

//--- core/msc_pkg.sv
/*
 * Types shared by the second-stream configuration bank.
 * Assumes msc_consts.svh is on the include path.
 */
`include "msc_consts.svh"

package msc_pkg;

    // ------------------------------------------------------------------
    // Line-start wait sequencer states, Gray along idle-wait-run
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MSC_IDLE = 2'h0,
        MSC_WAIT = 2'h1,
        MSC_RUN  = 2'h3
    } msc_state_t;

    // ------------------------------------------------------------------
    // Configuration handed to the framing datapath
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`MSC_WORD_COUNT_W-1:0] word_count;
        logic                         interlace;
        logic [`MSC_MIN_BYTES_W-1:0]  min_bytes;
        logic [`MSC_FRAC_BYTES_W-1:0] frac_bytes;
        logic [`MSC_LINE_WAIT_W-1:0]  line_wait;
        logic [`MSC_TU_SIZE_W-1:0]    tu_size;
    } msc_cfg_t;

endpackage

//--- core/msc_stream_cfg.sv
/*
 * Second-stream transfer-unit configuration bank with its line-start
 * wait sequencer: registers written by software, fields handed to the
 * framing logic, and the initial wait at the start of each line.
 * Assumes a synchronous register port with read data one cycle later,
 * and line start/end pulses from the framing logic on the same clock.
 */
`timescale 1ns/10ps
`include "msc_consts.svh"

module msc_stream_cfg #(
    parameter int WORD_COUNT_W = `MSC_WORD_COUNT_W
) (
    input  wire logic                   i_clk,          // 20 MHz clock
    input  wire logic                   i_rst,          // Async reset, high
    input  wire logic [`MSC_ADDR_W-1:0] i_addr,         // Byte address
    input  wire logic [`MSC_DATA_W-1:0] i_wdata,        // Write data
    input  wire logic                   i_wr,           // Write strobe
    input  wire logic                   i_rd,           // Read strobe
    output logic      [`MSC_DATA_W-1:0] o_rdata,        // Read data, next cycle
    output msc_pkg::msc_cfg_t           o_cfg,          // Fields to framing
    output logic                        o_vbid_interlace, // VBID interlace field
    output logic                        o_misc_interlace, // Attribute interlace field
    input  wire logic                   i_line_start,   // New line pulse
    input  wire logic                   i_line_end,     // Line done pulse
    output logic                        o_waiting,      // Initial wait running
    output logic                        o_line_go       // Wait over, pulse
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Framing struct carries a fixed field; a wider counter would be cut
    if (WORD_COUNT_W < 1 || WORD_COUNT_W > `MSC_WORD_COUNT_W) begin : g_bad_width
        $error("WORD_COUNT_W must lie between 1 and 16");
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [WORD_COUNT_W-1:0]        word_count;
    logic                           interlace;
    logic [`MSC_MIN_BYTES_W-1:0]    min_bytes;
    logic [`MSC_FRAC_BYTES_W-1:0]   frac_bytes;
    logic [`MSC_LINE_WAIT_W-1:0]    line_wait;
    logic [`MSC_TU_SIZE_W-1:0]      tu_size;
    logic [`MSC_DATA_W-1:0]         rdata;

    logic [WORD_COUNT_W-1:0]        next_word_count;
    logic                           next_interlace;
    logic [`MSC_MIN_BYTES_W-1:0]    next_min_bytes;
    logic [`MSC_FRAC_BYTES_W-1:0]   next_frac_bytes;
    logic [`MSC_LINE_WAIT_W-1:0]    next_line_wait;
    logic [`MSC_TU_SIZE_W-1:0]      next_tu_size;
    logic [`MSC_DATA_W-1:0]         next_rdata;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    always_comb begin
        next_word_count = word_count;
        next_interlace  = interlace;
        next_min_bytes  = min_bytes;
        next_frac_bytes = frac_bytes;
        next_line_wait  = line_wait;
        next_tu_size    = tu_size;
        if (i_wr) begin
            if (i_addr == `MSC_OFF_WORD_COUNT) begin
                next_word_count = i_wdata[WORD_COUNT_W-1:0];
            end else if (i_addr == `MSC_OFF_INTERLACE) begin
                next_interlace = i_wdata[`MSC_INTERLACE_BIT];
            end else if (i_addr == `MSC_OFF_MIN_BYTES) begin
                next_min_bytes = i_wdata[`MSC_MIN_BYTES_W-1:0];
            end else if (i_addr == `MSC_OFF_FRAC_BYTES) begin
                next_frac_bytes = i_wdata[`MSC_FRAC_BYTES_W-1:0];
            end else if (i_addr == `MSC_OFF_LINE_WAIT) begin
                next_line_wait = i_wdata[`MSC_LINE_WAIT_W-1:0];
            end else if (i_addr == `MSC_OFF_TU_SIZE) begin
                next_tu_size = {i_wdata[`MSC_TU_SIZE_W-1:1], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    // Data only in the cycle after the strobe; zero otherwise and unmapped
    always_comb begin
        next_rdata = '0;
        if (i_rd) begin
            if (i_addr == `MSC_OFF_WORD_COUNT) begin
                next_rdata = {{(`MSC_DATA_W-WORD_COUNT_W){1'b0}}, word_count};
            end else if (i_addr == `MSC_OFF_INTERLACE) begin
                next_rdata = {{(`MSC_DATA_W-1){1'b0}}, interlace};
            end else if (i_addr == `MSC_OFF_MIN_BYTES) begin
                next_rdata = {{(`MSC_DATA_W-`MSC_MIN_BYTES_W){1'b0}}, min_bytes};
            end else if (i_addr == `MSC_OFF_FRAC_BYTES) begin
                next_rdata = {{(`MSC_DATA_W-`MSC_FRAC_BYTES_W){1'b0}}, frac_bytes};
            end else if (i_addr == `MSC_OFF_LINE_WAIT) begin
                next_rdata = {{(`MSC_DATA_W-`MSC_LINE_WAIT_W){1'b0}}, line_wait};
            end else if (i_addr == `MSC_OFF_TU_SIZE) begin
                next_rdata = {{(`MSC_DATA_W-`MSC_TU_SIZE_W){1'b0}}, tu_size};
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            word_count <= '0;
            interlace  <= 1'b0;
            min_bytes  <= `MSC_RST_MIN_BYTES;
            frac_bytes <= `MSC_RST_FRAC_BYTES;
            line_wait  <= `MSC_RST_LINE_WAIT;
            tu_size    <= `MSC_RST_TU_SIZE;
            rdata      <= '0;
        end else begin
            word_count <= next_word_count;
            interlace  <= next_interlace;
            min_bytes  <= next_min_bytes;
            frac_bytes <= next_frac_bytes;
            line_wait  <= next_line_wait;
            tu_size    <= next_tu_size;
            rdata      <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the framing logic
    // ------------------------------------------------------------------
    // Struct field is fixed width; a narrower counter is zero-extended
    always_comb begin
        o_cfg            = '0;
        o_cfg.word_count = `MSC_WORD_COUNT_W'(word_count);
        o_cfg.interlace  = interlace;
        o_cfg.min_bytes  = min_bytes;
        o_cfg.frac_bytes = frac_bytes;
        o_cfg.line_wait  = line_wait;
        o_cfg.tu_size    = tu_size;
    end

    assign o_vbid_interlace = interlace;
    assign o_misc_interlace = interlace;
    assign o_rdata          = rdata;

    // ------------------------------------------------------------------
    // Line-start wait sequencer
    // ------------------------------------------------------------------
    msc_pkg::msc_state_t            state;
    msc_pkg::msc_state_t            next_state;
    logic [`MSC_LINE_WAIT_W-1:0]    wait_cnt;
    logic [`MSC_LINE_WAIT_W-1:0]    next_wait_cnt;
    logic                           line_go;
    logic                           next_line_go;
    logic                           waiting;
    logic                           next_waiting;

    // A new line start always restarts the wait, even mid-line, so a
    // missed line end cannot leave the framing logic running unpaced
    always_comb begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        next_line_go  = 1'b0;
        if (i_line_start) begin
            next_wait_cnt = line_wait;
            if (line_wait == '0) begin
                next_state   = msc_pkg::MSC_RUN;
                next_line_go = 1'b1;
            end else begin
                next_state = msc_pkg::MSC_WAIT;
            end
        end else begin
            case (state)
                msc_pkg::MSC_IDLE: begin
                    next_state = msc_pkg::MSC_IDLE;
                end
                msc_pkg::MSC_WAIT: begin
                    next_wait_cnt = wait_cnt - 1'b1;
                    if (wait_cnt == `MSC_LINE_WAIT_W'(1)) begin
                        next_state   = msc_pkg::MSC_RUN;
                        next_line_go = 1'b1;
                    end
                end
                msc_pkg::MSC_RUN: begin
                    if (i_line_end) begin
                        next_state = msc_pkg::MSC_IDLE;
                    end
                end
                default: begin
                    next_state = msc_pkg::MSC_IDLE;
                end
            endcase
        end
        // Own flop, so the framing side never sees a state decode glitch
        next_waiting = (next_state == msc_pkg::MSC_WAIT);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state    <= msc_pkg::MSC_IDLE;
            wait_cnt <= '0;
            line_go  <= 1'b0;
            waiting  <= 1'b0;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
            line_go  <= next_line_go;
            waiting  <= next_waiting;
        end
    end

    assign o_waiting = waiting;
    assign o_line_go = line_go;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Cycles since the last line start, and the wait it was given
    logic [`MSC_LINE_WAIT_W:0]      chk_elapsed;
    logic [`MSC_LINE_WAIT_W-1:0]    chk_wait;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            chk_elapsed <= '0;
            chk_wait    <= '0;
        end else if (i_line_start) begin
            chk_elapsed <= '0;
            chk_wait    <= line_wait;
        end else if (chk_elapsed != '1) begin
            chk_elapsed <= chk_elapsed + 1'b1;
        end
    end

    a_word_count_wr: assert property (
        i_wr && i_addr == `MSC_OFF_WORD_COUNT
        |=> o_cfg.word_count == `MSC_WORD_COUNT_W'($past(i_wdata[WORD_COUNT_W-1:0])))
        else $error("word count not stored");

    a_interlace_out: assert property (
        i_wr && i_addr == `MSC_OFF_INTERLACE
        |=> o_vbid_interlace == $past(i_wdata[0]) && o_misc_interlace == o_vbid_interlace)
        else $error("interlace fields do not follow bit 0");

    a_min_bytes_rd: assert property (
        i_wr && i_addr == `MSC_OFF_MIN_BYTES ##1 i_rd && i_addr == `MSC_OFF_MIN_BYTES
        |=> o_rdata == {24'h000000, $past(i_wdata[7:0], 2)})
        else $error("minimum bytes read-back wrong");

    a_frac_bytes_wr: assert property (
        i_wr && i_addr == `MSC_OFF_FRAC_BYTES
        |=> o_cfg.frac_bytes == $past(i_wdata[9:0]))
        else $error("fractional bytes not stored");

    a_wait_length: assert property (
        o_line_go |-> chk_elapsed == {1'b0, chk_wait})
        else $error("line start wait of wrong length");

    a_wait_hold: assert property (
        i_line_start && line_wait > 8'h01 |=> o_waiting && !o_line_go)
        else $error("wait not entered at line start");

    a_tu_size_even: assert property (
        o_cfg.tu_size[0] == 1'b0)
        else $error("transfer unit size odd");

    a_tu_size_reset: assert property (
        $past(i_rst) |-> o_cfg.tu_size == 7'h40)
        else $error("transfer unit size not 64 after reset");

    a_wait_zero: assert property (
        i_line_start && line_wait == 8'h00 |=> o_line_go && !o_waiting)
        else $error("zero wait did not go at once");

    a_line_wait_wr: assert property (
        i_wr && i_addr == `MSC_OFF_LINE_WAIT
        |=> o_cfg.line_wait == $past(i_wdata[`MSC_LINE_WAIT_W-1:0]))
        else $error("line wait not stored");

    a_cfg_hold: assert property (
        !i_wr |=> $stable(o_cfg))
        else $error("configuration changed without a write");

    a_read_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h00000000)
        else $error("read data outside the answer cycle");

endmodule

//--- verif/msc_stream_cfg_tb.sv
/*
 * Self-checking bench for the second-stream transfer-unit configuration bank.
 * Assumes msc_consts.svh on the include path; assertions live in the design.
 */
`timescale 1ns/10ps
`include "msc_consts.svh"

module msc_stream_cfg_tb;

    localparam int LIMIT = 20000;
    localparam logic [11:0] ADDRS [7] = '{`MSC_OFF_TU_SIZE, `MSC_OFF_WORD_COUNT,
        `MSC_OFF_INTERLACE, `MSC_OFF_MIN_BYTES, `MSC_OFF_FRAC_BYTES,
        `MSC_OFF_LINE_WAIT, 12'h550};

    logic              i_clk;
    logic              i_rst;
    logic [11:0]       i_addr;
    logic [31:0]       i_wdata;
    logic              i_wr;
    logic              i_rd;
    logic [31:0]       o_rdata;
    msc_pkg::msc_cfg_t o_cfg;
    logic              o_vbid_interlace;
    logic              o_misc_interlace;
    logic              i_line_start;
    logic              i_line_end;
    logic              o_waiting;
    logic              o_line_go;
    msc_pkg::msc_cfg_t exp_cfg;
    logic [31:0]       seed;
    logic [7:0]        mb;
    int                err_total = 0;
    int                checks = 0;
    int                cyc = 0;

    msc_stream_cfg uut (
        .i_clk            (i_clk),
        .i_rst            (i_rst),
        .i_addr           (i_addr),
        .i_wdata          (i_wdata),
        .i_wr             (i_wr),
        .i_rd             (i_rd),
        .o_rdata          (o_rdata),
        .o_cfg            (o_cfg),
        .o_vbid_interlace (o_vbid_interlace),
        .o_misc_interlace (o_misc_interlace),
        .i_line_start     (i_line_start),
        .i_line_end       (i_line_end),
        .o_waiting        (o_waiting),
        .o_line_go        (o_line_go)
    );

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------------
    // Checking, verdict and hang guard
    // ------------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] want, input string what);
        checks++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // Expectation functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    function automatic logic [15:0] lane_words(input int pix, input int lanes);
        int wpl;
        wpl = (pix * 24 + 15) / 16;
        return 16'(wpl + (wpl % lanes) - lanes);
    endfunction

    function automatic void model_wr(input logic [11:0] a, input logic [31:0] d);
        case (a)
            `MSC_OFF_TU_SIZE:    exp_cfg.tu_size = {d[6:1], 1'b0};
            `MSC_OFF_WORD_COUNT: exp_cfg.word_count = d[15:0];
            `MSC_OFF_INTERLACE:  exp_cfg.interlace = d[0];
            `MSC_OFF_MIN_BYTES:  exp_cfg.min_bytes = d[7:0];
            `MSC_OFF_FRAC_BYTES: exp_cfg.frac_bytes = d[9:0];
            `MSC_OFF_LINE_WAIT:  exp_cfg.line_wait = d[7:0];
            default: ;
        endcase
    endfunction

    function automatic logic [31:0] rd_exp(input logic [11:0] a);
        case (a)
            `MSC_OFF_TU_SIZE:    return {25'h0, exp_cfg.tu_size};
            `MSC_OFF_WORD_COUNT: return {16'h0, exp_cfg.word_count};
            `MSC_OFF_INTERLACE:  return {31'h0, exp_cfg.interlace};
            `MSC_OFF_MIN_BYTES:  return {24'h0, exp_cfg.min_bytes};
            `MSC_OFF_FRAC_BYTES: return {22'h0, exp_cfg.frac_bytes};
            `MSC_OFF_LINE_WAIT:  return {24'h0, exp_cfg.line_wait};
            default:             return 32'h0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Register port and line tasks, entered just after a rising edge
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        model_wr(a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(64'(o_rdata), 64'(rd_exp(a)), "read data");
        chk(64'(o_cfg), 64'(exp_cfg), "config fields");
        chk(64'({o_vbid_interlace, o_misc_interlace}), {62'h0, {2{exp_cfg.interlace}}},
            "interlace fields");
        @(negedge i_clk);
        chk(64'(o_rdata), 64'h0, "read data idle");
        @(posedge i_clk);
    endtask

    task automatic line_run(input logic [7:0] w);
        int last;
        // Wait of w cycles: waiting in cycles 1..w, go in cycle w+1
        last = int'(w) + 2;
        wr(`MSC_OFF_LINE_WAIT, {24'h0, w});
        i_line_start <= 1'b1;
        @(posedge i_clk);
        i_line_start <= 1'b0;
        for (int k = 1; k <= last; k++) begin
            @(negedge i_clk);
            chk(64'(o_waiting), 64'(k <= int'(w)), "waiting");
            chk(64'(o_line_go), 64'(k == int'(w) + 1), "line go");
            @(posedge i_clk);
        end
        i_line_end <= 1'b1;
        @(posedge i_clk);
        i_line_end <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        i_addr = 12'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_line_start = 1'b0;
        i_line_end = 1'b0;
        seed = 32'h8f49;
        exp_cfg = '0;
        exp_cfg.tu_size = 7'h40;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (ADDRS[i]) rd_chk(ADDRS[i]);
        $display("test reset values done");
        // All-ones then bit 0 clear: catches stuck bit 0 and upper bits
        foreach (ADDRS[i]) begin
            wr(ADDRS[i], 32'hffffffff);
            rd_chk(ADDRS[i]);
            wr(ADDRS[i], 32'hfffffffe);
            rd_chk(ADDRS[i]);
        end
        repeat (60) begin
            seed = lfsr(seed);
            mb = seed[7:0];
            seed = lfsr(seed);
            wr(ADDRS[int'(mb) % 7], seed);
            rd_chk(ADDRS[int'(mb) % 7]);
        end
        $display("test register access done");
        for (int l = 1; l <= 4; l = l * 2) begin
            seed = lfsr(seed);
            wr(`MSC_OFF_WORD_COUNT, {16'h0, lane_words(int'(seed[11:0]) + 1, l)});
            rd_chk(`MSC_OFF_WORD_COUNT);
        end
        // Interlaced source flagged by software
        wr(`MSC_OFF_INTERLACE, 32'h1);
        rd_chk(`MSC_OFF_INTERLACE);
        wr(`MSC_OFF_TU_SIZE, 32'h40);
        foreach (ADDRS[i]) begin
            seed = lfsr(seed);
            mb = (i < 2) ? 8'(3 + i) : {2'h0, seed[5:0]};
            wr(`MSC_OFF_MIN_BYTES, {24'h0, mb});
            wr(`MSC_OFF_FRAC_BYTES, {22'h0, seed[17:8]});
            rd_chk(`MSC_OFF_FRAC_BYTES);
            line_run((mb <= 8'h4) ? 8'h40 : 8'({1'b0, exp_cfg.tu_size} - mb));
        end
        line_run(8'h0);
        line_run(8'h2);
        line_run(8'hff);
        $display("test line wait done");
        wr(`MSC_OFF_LINE_WAIT, 32'hc8);
        i_line_start <= 1'b1;
        @(posedge i_clk);
        i_line_start <= 1'b0;
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        chk(64'({o_waiting, o_line_go}), 64'h2, "wait before reset");
        @(posedge i_clk);
        i_rst <= 1'b1;
        @(negedge i_clk);
        exp_cfg = '0;
        exp_cfg.tu_size = 7'h40;
        chk(64'(o_cfg), 64'(exp_cfg), "config after reset");
        chk(64'({o_waiting, o_line_go}), 64'h0, "wait after reset");
        chk(64'(o_rdata), 64'h0, "read data after reset");
        @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (ADDRS[i]) rd_chk(ADDRS[i]);
        $display("test mid-run reset done");
        wrap_up();
    end

endmodule
